/* verilog/ea_calc_pkg.sv */
// Package for the effective-address calculator: field codes, sizes, reset values.
// Assumes a single core clock domain and 32-bit addresses.
package ea_calc_pkg;

  localparam int ADDR_W = 32;

  // Displacement / operand size codes
  localparam logic [1:0] SZ_NONE = 2'h0;
  localparam logic [1:0] SZ_BYTE = 2'h1;
  localparam logic [1:0] SZ_WORD = 2'h2;
  localparam logic [1:0] SZ_LONG = 2'h3;

  // Index scale codes: shift amount 0..3 for x1, x2, x4, x8
  localparam logic [1:0] SCALE_1 = 2'h0;
  localparam logic [1:0] SCALE_2 = 2'h1;
  localparam logic [1:0] SCALE_4 = 2'h2;
  localparam logic [1:0] SCALE_8 = 2'h3;

  // Reset values
  localparam logic [31:0] ADDR_RST = 32'h0000_0000;
  localparam logic [31:0] IMM_RST  = 32'h0000_0000;

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_FETCH,
    ST_DONE
  } ea_state_t;

endpackage : ea_calc_pkg

/* verilog/ea_sext.sv */
// Size-selected sign extension of a 32-bit field to address width.
// Purely combinational; used for every displacement and the index.
`timescale 1ns/1ps
`default_nettype none
module ea_sext
  import ea_calc_pkg::*;
(
  // Field in
  input  wire logic [31:0] raw,
  input  wire logic [1:0]  size,
  // Extended value
  output logic      [31:0] ext
);

  // Absent field contributes zero
  assign ext = (size == SZ_BYTE) ? {{24{raw[7]}}, raw[7:0]} :
               (size == SZ_WORD) ? {{16{raw[15]}}, raw[15:0]} :
               (size == SZ_LONG) ? raw : 32'h0000_0000;

endmodule : ea_sext
`default_nettype wire

/* verilog/effective_address_calc.sv */
// Effective-address calculator between instruction decode and operand access.
// Assumes the decoder holds request fields stable while busy is high and that
// the memory side answers a long-word read with rd_valid, one pulse per read.
`timescale 1ns/1ps
`default_nettype none
module effective_address_calc
  import ea_calc_pkg::*;
(
  // Clock and reset
  input  wire logic        clock,
  input  wire logic        rst_n,
  // Request from decode
  input  wire logic        req,
  // Base selection
  input  wire logic        use_pc,
  input  wire logic [31:0] base_reg,
  input  wire logic [31:0] pc_value,
  input  wire logic        base_suppress,
  // Displacements
  input  wire logic [31:0] short_disp,
  input  wire logic [1:0]  short_disp_size,
  input  wire logic [31:0] base_disp,
  input  wire logic [1:0]  base_disp_size,
  // Index
  input  wire logic [31:0] index_reg,
  input  wire logic        index_long,
  input  wire logic [1:0]  index_scale,
  input  wire logic        index_suppress,
  // Indirection
  input  wire logic        indirect,
  input  wire logic        post_index,
  input  wire logic [31:0] outer_disp,
  input  wire logic [1:0]  outer_disp_size,
  // Immediate
  input  wire logic [31:0] imm_word,
  input  wire logic [1:0]  imm_size,
  // Operand memory read port
  output logic             rd_req,
  output logic      [31:0] rd_addr,
  input  wire logic        rd_valid,
  input  wire logic [31:0] rd_data,
  // Results
  output logic             busy,
  output logic             ea_valid,
  output logic      [31:0] ea_addr,
  output logic      [31:0] imm_value
);

  ////////////////////////////////////////////////////////////////////////////
  // Component extension

  logic [31:0] short_ext;
  logic [31:0] base_ext;
  logic [31:0] outer_ext;
  logic [31:0] index_ext;
  logic [31:0] imm_ext;

  ea_sext u_short (.raw(short_disp), .size(short_disp_size), .ext(short_ext));
  ea_sext u_base  (.raw(base_disp),  .size(base_disp_size),  .ext(base_ext));
  ea_sext u_outer (.raw(outer_disp), .size(outer_disp_size), .ext(outer_ext));
  ea_sext u_imm   (.raw(imm_word),   .size(imm_size),        .ext(imm_ext));

  ////////////////////////////////////////////////////////////////////////////
  // Index sizing and scaling

  // Scaling is a plain shift; every two-bit code is a legal factor
  function automatic logic [31:0] scale_index(input logic [31:0] value,
                                              input logic [1:0]  scale);
    case (scale)
      SCALE_1: return value;
      SCALE_2: return {value[30:0], 1'h0};
      SCALE_4: return {value[29:0], 2'h0};
      SCALE_8: return {value[28:0], 3'h0};
      default: return value;
    endcase
  endfunction : scale_index

  logic [1:0]  index_size;
  logic [31:0] index_sized;

  // Word index is sign-extended, long index used whole
  assign index_size = index_long ? SZ_LONG : SZ_WORD;
  ea_sext u_index (.raw(index_reg), .size(index_size), .ext(index_sized));
  assign index_ext = index_suppress ? 32'h0000_0000 :
                     scale_index(index_sized, index_scale);

  wire [31:0] base_val = base_suppress ? 32'h0000_0000 :
                         (use_pc ? pc_value : base_reg);

  // Preindexed: index inside brackets; postindexed: after the fetch
  wire [31:0] idx_inner = (indirect && post_index) ? 32'h0000_0000 : index_ext;
  wire [31:0] idx_outer = (indirect && post_index) ? index_ext : 32'h0000_0000;

  // Sums wrap at 32 bits, as all address arithmetic does
  wire [31:0] inner_sum = base_val + short_ext + base_ext + idx_inner;
  wire [31:0] final_sum = rd_data + idx_outer + outer_ext;

  ////////////////////////////////////////////////////////////////////////////
  // Control decode

  ea_state_t   state_reg;
  ea_state_t   state_next;
  logic        is_idle;
  logic        accept;
  logic        accept_direct;
  logic        accept_indirect;
  logic        fetch_done;

  assign is_idle         = (state_reg == ST_IDLE);
  // Requests while busy are dropped with no indication
  assign accept          = is_idle && req;
  assign accept_direct   = accept && !indirect;
  assign accept_indirect = accept && indirect;
  // A read answer outside a fetch is ignored
  assign fetch_done      = (state_reg == ST_FETCH) && rd_valid;

  ////////////////////////////////////////////////////////////////////////////
  // Next values

  logic        rd_req_next;
  logic        ea_valid_next;
  logic        busy_next;
  logic [31:0] rd_addr_next;
  logic [31:0] ea_addr_next;
  logic [31:0] imm_next;

  // Single-cycle strobes straight from the decode; busy from the next state
  assign rd_req_next   = accept_indirect;
  assign ea_valid_next = accept_direct || fetch_done;
  assign busy_next     = (state_next != ST_IDLE);
  // Bracketed value becomes the read address
  assign rd_addr_next  = accept_indirect ? inner_sum : rd_addr;
  // Outer displacement waits for the fetched long word
  assign ea_addr_next  = accept_direct ? inner_sum :
                         (fetch_done ? final_sum : ea_addr);
  // Immediate taken once at accept, then held
  assign imm_next      = accept ? imm_ext : imm_value;

  ////////////////////////////////////////////////////////////////////////////
  // Sequencing

  always_comb begin
    state_next = state_reg;
    case (state_reg)
      ST_IDLE: begin
        if (accept_indirect) begin
          state_next = ST_FETCH;
        end else if (accept_direct) begin
          state_next = ST_DONE;
        end
      end
      ST_FETCH: begin
        // Holds here until the long word comes back
        if (fetch_done) begin
          state_next = ST_DONE;
        end
      end
      ST_DONE: begin
        // One done cycle, busy with ea_valid high, keeps back-to-back requests cleanly separated
        state_next = ST_IDLE;
      end
      default: begin
        state_next = ST_IDLE;
      end
    endcase
  end

  // Busy mirrors the next state, so it rises with the accept edge
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= ST_IDLE;
      busy      <= 1'b0;
    end else begin
      state_reg <= state_next;
      busy      <= busy_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Output registers

  // Read port: address holds until the next indirect request
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      rd_req  <= 1'b0;
      rd_addr <= ADDR_RST;
    end else begin
      rd_req  <= rd_req_next;
      rd_addr <= rd_addr_next;
    end
  end

  // Result strobe and address move together
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      ea_valid <= 1'b0;
      ea_addr  <= ADDR_RST;
    end else begin
      ea_valid <= ea_valid_next;
      ea_addr  <= ea_addr_next;
    end
  end

  // Immediate
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      imm_value <= IMM_RST;
    end else begin
      imm_value <= imm_next;
    end
  end

endmodule : effective_address_calc
`default_nettype wire

/* verification/ea_calc_asserts.sv */
// Checker for request, fetch and result timing of the address calculator.
// Assumes one clock domain; bound to the top module at the foot.
`timescale 1ns/1ps
`default_nettype none
module ea_calc_asserts
  import ea_calc_pkg::*;
(
  // Clock and request
  input wire logic        clock,
  input wire logic        rst_n,
  input wire logic        req,
  input wire logic        indirect,
  input wire logic [1:0]  imm_size,
  input wire logic [31:0] imm_word,
  // Results
  input wire logic        busy,
  input wire logic        rd_req,
  input wire logic        rd_valid,
  input wire logic        ea_valid,
  input wire logic [31:0] imm_value
);
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_n);
  property p_dir; req && !busy && !indirect |=> ea_valid && busy; endproperty
  a_dir: assert property (p_dir) else $error("direct result late");
  property p_ind; req && !busy && indirect |=> rd_req && !ea_valid; endproperty
  a_ind: assert property (p_ind) else $error("no fetch");
  property p_rdp; rd_req |=> !rd_req; endproperty
  a_rdp: assert property (p_rdp) else $error("read pulse long");
  property p_ret; busy && !ea_valid && rd_valid |=> ea_valid; endproperty
  a_ret: assert property (p_ret) else $error("no result after fetch");
  property p_one; ea_valid |=> !ea_valid && !busy; endproperty
  a_one: assert property (p_one) else $error("result not single");
  property p_imw; req && !busy && imm_size == SZ_WORD
    |=> imm_value == {{16{$past(imm_word[15])}}, $past(imm_word[15:0])}; endproperty
  a_imw: assert property (p_imw) else $error("word immediate");
  property p_imz; req && !busy && imm_size == SZ_NONE |=> imm_value == 32'h0; endproperty
  a_imz: assert property (p_imz) else $error("absent immediate");
endmodule : ea_calc_asserts
bind effective_address_calc ea_calc_asserts chk_u (.*);
`default_nettype wire

/* verification/ea_mem_model.sv */
// Operand memory: answers each read after 0..3 cycles with the inverted address.
// Assumes rd_addr holds while a read is pending.
`timescale 1ns/1ps
`default_nettype none
module ea_mem_model (
  // Read port
  input  wire logic        clock,
  input  wire logic        rd_req,
  input  wire logic [31:0] rd_addr,
  output logic             rd_valid,
  output logic      [31:0] rd_data
);
  initial begin
    rd_valid = 1'b0;
    rd_data  = 32'h0;
    forever begin
      @(negedge clock);
      if (rd_req) begin
        repeat ($urandom_range(3)) @(negedge clock);
        rd_valid = 1'b1;
        rd_data  = ~rd_addr;
        @(negedge clock);
        rd_valid = 1'b0;
        rd_data  = rd_addr; // Stale data never looks valid
      end
    end
  end
endmodule : ea_mem_model
`default_nettype wire

/* verification/tb.sv */
// Bench: random direct and indirect requests, results checked in order.
// Assumes the memory model answers every read.
`timescale 1ns/1ps
`default_nettype none
module tb;
  import ea_calc_pkg::*;
  logic clock, rst_n, req = 0, use_pc = 0, base_suppress = 0, index_long = 0;
  logic index_suppress = 0, indirect = 0, post_index = 0, rd_req, rd_valid, busy, ea_valid;
  logic [31:0] base_reg = 0, pc_value = 0, short_disp = 0, base_disp = 0, index_reg = 0;
  logic [31:0] outer_disp = 0, imm_word = 0, rd_addr, rd_data, ea_addr, imm_value;
  logic [1:0]  short_disp_size = 0, base_disp_size = 0, index_scale = 0;
  logic [1:0]  outer_disp_size = 0, imm_size = 0;
  logic [63:0] exp_q[$];
  logic [63:0] e;
  int          n_mismatch = 0, n_tests = 0;
  effective_address_calc dut_u (.*);
  ea_mem_model mem_u (.*);
  function automatic logic [31:0] sx(input logic [31:0] v, input logic [1:0] s);
    case (s)
      SZ_BYTE: return {{24{v[7]}}, v[7:0]};
      SZ_WORD: return {{16{v[15]}}, v[15:0]};
      SZ_LONG: return v;
      default: return 32'h0;
    endcase
  endfunction : sx
  task automatic cmp_addr(input logic [31:0] got, exp);
    n_tests++;
    if (got !== exp) begin
      n_mismatch++;
      $display("wrong value at %0t ea_addr %h exp %h", $time, got, exp);
    end
  endtask : cmp_addr
  task automatic cmp_imm(input logic [31:0] got, exp);
    n_tests++;
    if (got !== exp) begin
      n_mismatch++;
      $display("wrong value at %0t imm_value %h exp %h", $time, got, exp);
    end
  endtask : cmp_imm
  task automatic run_one(input int n);
    logic [31:0] b, ix, a;
    @(negedge clock);
    {use_pc, base_suppress, index_long, index_suppress, indirect, post_index} = 6'($urandom);
    {base_reg, pc_value, short_disp, base_disp} = {$urandom, $urandom, $urandom, $urandom};
    {index_reg, outer_disp, imm_word} = {$urandom, $urandom, $urandom};
    {index_scale, outer_disp_size, imm_size, base_disp_size} = 8'($urandom);
    short_disp_size = 2'($urandom_range(2));
    if (base_disp_size == SZ_BYTE) base_disp_size = SZ_NONE;
    if (outer_disp_size == SZ_BYTE) outer_disp_size = SZ_LONG;
    b = (base_suppress ? 32'h0 : (use_pc ? pc_value : base_reg)) + sx(short_disp, short_disp_size);
    b = b + sx(base_disp, base_disp_size);
    ix = index_suppress ? 32'h0 : ((index_long ? index_reg : sx(index_reg, SZ_WORD)) << index_scale);
    if (!indirect) a = b + ix;
    else if (post_index) a = ~b + ix + sx(outer_disp, outer_disp_size);
    else a = ~(b + ix) + sx(outer_disp, outer_disp_size);
    exp_q.push_back({a, sx(imm_word, imm_size)});
    req = 1'b1;
    @(negedge clock);
    req = 1'b0;
    for (int i = 0; i < 20 && busy !== 1'b0; i++) @(negedge clock);
    // A request that never finishes counts against the run
    if (busy !== 1'b0) begin
      n_mismatch++;
      $display("wrong value at %0t busy %h exp %h", $time, busy, 1'b0);
    end
    $display("test %0d done", n);
  endtask : run_one
  // Outputs are settled by the falling edge; the strobe stands one cycle
  always @(negedge clock) begin
    if (ea_valid === 1'b1) begin
      if (exp_q.size() == 0) begin
        n_mismatch++;
        $display("wrong value at %0t ea_addr %h exp none", $time, ea_addr);
      end else begin
        e = exp_q.pop_front();
        cmp_addr(ea_addr, e[63:32]);
        cmp_imm(imm_value, e[31:0]);
      end
    end
  end
  task automatic complete_run;
    $display("comparisons %0d mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : complete_run
  initial begin
    clock = 1'b0;
    forever #4 clock = ~clock;
  end
  initial begin
    rst_n = 1'b0;
    void'($urandom(32'h9AF8B3F9));
    repeat (6) @(negedge clock);
    rst_n = 1'b1;
    for (int n = 0; n < 200; n++) run_one(n);
    repeat (4) @(negedge clock);
    // Every noted request must have produced its result
    if (exp_q.size() != 0) begin
      n_mismatch++;
      $display("wrong value at %0t pending %h exp %h", $time, exp_q.size(), 32'h0);
    end
    complete_run();
  end
  initial begin
    #40000;
    n_mismatch++;
    complete_run();
  end
endmodule : tb
`default_nettype wire
